// File: core/bmw_lane_merge.sv
// per-lane merge of a new word over a stored word
// assumes active-low lane selects, one per 9-bit lane, lane 0 in the low bits
`timescale 1ns/1ps
module bmw_lane_merge #(
    parameter int WORD_W = bmw_pkg::BMW_WORD_W_X18, // word width
    parameter int LANE_W = bmw_pkg::BMW_LANE_W       // lane width
) (
    input wire logic [WORD_W-1:0] old_word,           // stored contents
    input wire logic [WORD_W-1:0] new_word,           // incoming contents
    input wire logic [WORD_W/LANE_W-1:0] sel_n,       // low takes the new lane
    output logic [WORD_W-1:0] merged                  // resulting word
);
    import bmw_pkg::*;
    localparam int LANES = WORD_W / LANE_W;

    for (genvar i = 0; i < LANES; i++) begin : g_lane
        // a high select keeps the stored lane untouched
        assign merged[i*LANE_W +: LANE_W] = sel_n[i] ? old_word[i*LANE_W +: LANE_W]
                                                     : new_word[i*LANE_W +: LANE_W];
    end
endmodule

// File: core/bmw_pkg.sv
// package for the byte-masked two-word burst write sram block
// assumes one core clock; each core cycle carries both data halves of a burst
package bmw_pkg;
    localparam int BMW_LANE_W = 9;         // bits per byte lane
    localparam int BMW_WORD_W_X18 = 18;    // narrow device word width
    localparam int BMW_WORD_W_X36 = 36;    // wide device word width
    localparam int BMW_ADDR_W_X18 = 21;    // burst locations of the narrow device
    localparam int BMW_ADDR_W_X36 = 20;    // burst locations of the wide device
    localparam int BMW_WR_DATA_LAT = 1;    // load cycle to write data cycle
    localparam int BMW_RD_LAT = 2;         // read fetch cycle to read data cycle
    localparam int BMW_BURST_LEN = 2;      // words per burst
    localparam logic BMW_RST_OE = 1'b0;    // outputs deselected after reset
    localparam logic BMW_RST_POST_VALID = 1'b0;

    // operation held for the cycle after load; gray along nop -> wr -> rd
    typedef enum logic [1:0] {
        BMW_OP_NOP = 2'b00,
        BMW_OP_WR = 2'b01,
        BMW_OP_RD = 2'b11
    } bmw_op_e;
endpackage

// File: core/bmw_store.sv
// flip-flop array of two-word burst locations
// assumes one write port and two combinational read ports, all by location index
`timescale 1ns/1ps
module bmw_store #(
    parameter int WORD_W = bmw_pkg::BMW_WORD_W_X18, // word width
    parameter int ADDR_W = bmw_pkg::BMW_ADDR_W_X18  // location address width
) (
    input wire logic clk,                           // core clock
    input wire logic ce,                            // clock enable
    input wire logic we,                            // write both words of a location
    input wire logic [ADDR_W-1:0] waddr,            // write location
    input wire logic [WORD_W-1:0] wdata0,           // word for address a
    input wire logic [WORD_W-1:0] wdata1,           // word for address a + 1
    input wire logic [ADDR_W-1:0] raddr,            // read location
    output logic [WORD_W-1:0] rdata0,               // word a at raddr
    output logic [WORD_W-1:0] rdata1,               // word a + 1 at raddr
    output logic [WORD_W-1:0] wold0,                // word a at waddr
    output logic [WORD_W-1:0] wold1                 // word a + 1 at waddr
);
    import bmw_pkg::*;
    localparam int WORDS = BMW_BURST_LEN << ADDR_W;

    logic [WORD_W-1:0] mem [WORDS];
    logic [ADDR_W:0] widx0;
    logic [ADDR_W:0] widx1;
    logic [ADDR_W:0] ridx0;
    logic [ADDR_W:0] ridx1;

    // second word of a burst lands on the following word index
    assign widx0 = {waddr, 1'b0};
    assign widx1 = widx0 + (ADDR_W+1)'(1);
    assign ridx0 = {raddr, 1'b0};
    assign ridx1 = ridx0 + (ADDR_W+1)'(1);

    assign rdata0 = mem[ridx0];
    assign rdata1 = mem[ridx1];
    assign wold0 = mem[widx0];
    assign wold1 = mem[widx1];

    // no reset: array contents are undefined at power up, like the part
    always_ff @(posedge clk) begin
        if (ce && we) begin
            mem[widx0] <= wdata0;
            mem[widx1] <= wdata1;
        end
    end
endmodule

// File: core/bmw_top.sv
// byte-masked two-word burst sram core: posted writes, lane merge, read bypass
// assumes the controller presents the k-rise and k#-rise halves of a data cycle
// side by side on one core clock edge; dq_oe drives the shared data pins
//
// Contract
// - narrow part, both selects low writes the whole 18-bit word on that edge.
// - narrow part, select 0 only writes bits 8..0, keeps bits 17..9.
// - narrow part, select 1 only writes bits 17..9, keeps bits 8..0.
// - wide part, all four selects low writes all 36 bits of the word.
// - wide part, select 0 writes 8..0 only, select 1 writes 17..9 only.
// - wide part, select 2 writes 26..18 only, select 3 writes 35..27 only.
// - all selects high in one data half writes nothing for that half.
// - each data half samples its own lane selects as its own mask.
// - write data taken on both clock rises; read data delivered on both.
// - second burst word goes to the address following the latched one.
// - cycle t is the load cycle; t+1 and t+2 are the next two.
// - after power up outputs stay deselected until a valid operation loads.
// - read right after a write returns the newest data from holding registers.
`timescale 1ns/1ps
module bmw_top #(
    parameter int WORD_W = bmw_pkg::BMW_WORD_W_X18, // 18 or 36
    parameter int ADDR_W = bmw_pkg::BMW_ADDR_W_X18  // burst location address width
) (
    input wire logic clk,                                          // core clock
    input wire logic rst,                                          // sync reset, high
    input wire logic ce,                                           // clock enable
    input wire logic load_request_n,                               // low loads an op
    input wire logic read_not_write,                               // high read, low write
    input wire logic [ADDR_W-1:0] addr,                            // burst address
    input wire logic [WORD_W-1:0] wr_data_k,                       // word at k rise
    input wire logic [WORD_W-1:0] wr_data_kn,                      // word at k# rise
    input wire logic [WORD_W/bmw_pkg::BMW_LANE_W-1:0] lane_write_select_n_k,  // k mask
    input wire logic [WORD_W/bmw_pkg::BMW_LANE_W-1:0] lane_write_select_n_kn, // k# mask
    output logic [WORD_W-1:0] rd_data_k,                           // read word a
    output logic [WORD_W-1:0] rd_data_kn,                          // read word a + 1
    output logic dq_oe                                             // data pins driven
);
    import bmw_pkg::*;
    localparam int LANES = WORD_W / BMW_LANE_W;

    bmw_op_e op_q;
    logic [ADDR_W-1:0] addr_q;
    logic post_valid;
    logic [ADDR_W-1:0] post_addr;
    logic [WORD_W-1:0] post_k;
    logic [WORD_W-1:0] post_kn;
    logic [LANES-1:0] post_sel_k_n;
    logic [LANES-1:0] post_sel_kn_n;
    logic rd_pend;
    logic [WORD_W-1:0] rd_buf_k;
    logic [WORD_W-1:0] rd_buf_kn;

    logic wr_load;
    logic rd_load;
    logic wr_capture;
    logic commit;
    logic hit;
    logic [WORD_W-1:0] arr_k;
    logic [WORD_W-1:0] arr_kn;
    logic [WORD_W-1:0] old_k;
    logic [WORD_W-1:0] old_kn;
    logic [WORD_W-1:0] merged_k;
    logic [WORD_W-1:0] merged_kn;
    logic [WORD_W-1:0] byp_k;
    logic [WORD_W-1:0] byp_kn;
    logic [WORD_W-1:0] next_rd_k;
    logic [WORD_W-1:0] next_rd_kn;

    // the write load at cycle t; its data arrives in cycle t+1
    assign wr_load = !load_request_n && !read_not_write;
    assign rd_load = !load_request_n && read_not_write;
    assign wr_capture = (op_q == BMW_OP_WR);
    // a posted write reaches the array at the next write load, or at the latest when a
    // newer write's data would overwrite it; back-to-back writes would otherwise lose one
    assign commit = post_valid && (wr_load || wr_capture);
    assign hit = post_valid && (post_addr == addr_q);

    always_ff @(posedge clk) begin
        if (rst) begin
            op_q <= BMW_OP_NOP;
        end else if (ce) begin
            if (wr_load) begin
                op_q <= BMW_OP_WR;
            end else if (rd_load) begin
                op_q <= BMW_OP_RD;
            end else begin
                op_q <= BMW_OP_NOP;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (ce && !load_request_n) begin
            addr_q <= addr;
        end
    end

    // posted write register: both words and both masks travel together
    always_ff @(posedge clk) begin
        if (rst) begin
            post_valid <= BMW_RST_POST_VALID;
        end else if (ce) begin
            if (wr_capture) begin
                post_valid <= 1'b1;
            end else if (commit) begin
                post_valid <= 1'b0;
            end
        end
    end

    // each half latches its own data and its own mask
    always_ff @(posedge clk) begin
        if (ce && wr_capture) begin
            post_addr <= addr_q;
            post_k <= wr_data_k;
            post_kn <= wr_data_kn;
            post_sel_k_n <= lane_write_select_n_k;
            post_sel_kn_n <= lane_write_select_n_kn;
        end
    end

    bmw_store #(
        .WORD_W(WORD_W),
        .ADDR_W(ADDR_W)
    ) u_store (
        .clk(clk),
        .ce(ce),
        .we(commit),
        .waddr(post_addr),
        .wdata0(merged_k),
        .wdata1(merged_kn),
        .raddr(addr_q),
        .rdata0(arr_k),
        .rdata1(arr_kn),
        .wold0(old_k),
        .wold1(old_kn)
    );

    // commit merge: deselected lanes keep stored bits
    bmw_lane_merge #(
        .WORD_W(WORD_W),
        .LANE_W(BMW_LANE_W)
    ) u_merge_k (
        .old_word(old_k),
        .new_word(post_k),
        .sel_n(post_sel_k_n),
        .merged(merged_k)
    );

    bmw_lane_merge #(
        .WORD_W(WORD_W),
        .LANE_W(BMW_LANE_W)
    ) u_merge_kn (
        .old_word(old_kn),
        .new_word(post_kn),
        .sel_n(post_sel_kn_n),
        .merged(merged_kn)
    );

    // read bypass overlays the posted lanes on the array word
    bmw_lane_merge #(
        .WORD_W(WORD_W),
        .LANE_W(BMW_LANE_W)
    ) u_byp_k (
        .old_word(arr_k),
        .new_word(post_k),
        .sel_n(post_sel_k_n),
        .merged(byp_k)
    );

    bmw_lane_merge #(
        .WORD_W(WORD_W),
        .LANE_W(BMW_LANE_W)
    ) u_byp_kn (
        .old_word(arr_kn),
        .new_word(post_kn),
        .sel_n(post_sel_kn_n),
        .merged(byp_kn)
    );

    assign next_rd_k = hit ? byp_k : arr_k;
    assign next_rd_kn = hit ? byp_kn : arr_kn;

    // read fetch in cycle t+1, drive in cycle t+3
    always_ff @(posedge clk) begin
        if (rst) begin
            rd_pend <= 1'b0;
        end else if (ce) begin
            rd_pend <= (op_q == BMW_OP_RD);
        end
    end

    always_ff @(posedge clk) begin
        if (ce && op_q == BMW_OP_RD) begin
            rd_buf_k <= next_rd_k;
            rd_buf_kn <= next_rd_kn;
        end
    end

    // powers up deselected; pins float except in a read data cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            dq_oe <= BMW_RST_OE;
            rd_data_k <= '0;
            rd_data_kn <= '0;
        end else if (ce) begin
            dq_oe <= rd_pend;
            if (rd_pend) begin
                rd_data_k <= rd_buf_k;
                rd_data_kn <= rd_buf_kn;
            end
        end
    end

    // checks count enabled cycles only, so a frozen clock enable is invisible
    sequence s_rd_load;
        !load_request_n && read_not_write;
    endsequence

    // back-to-back reads keep the pins driven, so only the drive cycle itself is checked
    sequence s_rd_drive;
        1'b1 ##3 dq_oe;
    endsequence

    read_window_a: assert property (@(posedge clk iff ce) disable iff (rst)
        s_rd_load |-> s_rd_drive)
        else $error("read data not driven in the cycle after t+2");

    deselect_a: assert property (@(posedge clk iff ce) disable iff (rst)
        dq_oe |-> $past(rd_load, 3))
        else $error("data pins driven without a read loaded");

    split_mask_a: assert property (@(posedge clk iff ce) disable iff (rst)
        wr_load ##1 1'b1 |=> post_sel_k_n == $past(lane_write_select_n_k)
            && post_sel_kn_n == $past(lane_write_select_n_kn) && post_valid)
        else $error("write half masks not captured separately");

    posted_hold_a: assert property (@(posedge clk iff ce) disable iff (rst)
        post_valid && !wr_capture |=> $stable(post_sel_k_n) && $stable(post_sel_kn_n)
            && $stable(post_k) && $stable(post_kn))
        else $error("posted write changed before array write");

    full_word_a: assert property (@(posedge clk iff ce) disable iff (rst)
        commit && post_sel_k_n == '0 |-> merged_k == post_k)
        else $error("full mask did not write the whole word");

    nothing_written_a: assert property (@(posedge clk iff ce) disable iff (rst)
        commit && &post_sel_kn_n |-> merged_kn == old_kn)
        else $error("all selects high still changed the word");

    low_lane_a: assert property (@(posedge clk iff ce) disable iff (rst)
        commit && !post_sel_k_n[0] && &post_sel_k_n[LANES-1:1]
            |-> merged_k[BMW_LANE_W-1:0] == post_k[BMW_LANE_W-1:0]
            && merged_k[WORD_W-1:BMW_LANE_W] == old_k[WORD_W-1:BMW_LANE_W])
        else $error("low lane write disturbed other lanes");

    top_lane_a: assert property (@(posedge clk iff ce) disable iff (rst)
        commit && !post_sel_kn_n[LANES-1] |-> merged_kn[WORD_W-1 -: BMW_LANE_W]
            == post_kn[WORD_W-1 -: BMW_LANE_W])
        else $error("top lane not written");

    bypass_newest_a: assert property (@(posedge clk iff ce) disable iff (rst)
        op_q == BMW_OP_RD && hit && post_sel_k_n == '0 ##1 1'b1 |=> rd_data_k == $past(post_k, 2))
        else $error("read after write missed the posted data");
endmodule

// File: sim/bmw_ctrl_model.sv
// memory controller model: load, direction, address, write data and lane masks
// assumes the bench holds a request until ready is seen high at an enabled edge
`timescale 1ns/1ps
module bmw_ctrl_model (
    input wire logic clk,               // core clock
    input wire logic rst,               // sync reset, high
    input wire logic ce,                // clock enable
    input wire logic req,               // request held by the bench
    input wire logic req_rnw,           // high read
    input wire logic [3:0] req_addr,    // burst address
    input wire logic [35:0] req_d0,     // word a
    input wire logic [35:0] req_d1,     // word a + 1
    input wire logic [3:0] req_m0,      // mask of word a
    input wire logic [3:0] req_m1,      // mask of word a + 1
    output logic ready,                 // request may be taken
    output logic load_request_n,        // low loads an op
    output logic read_not_write,        // high read
    output logic [3:0] addr,            // burst address
    output logic [35:0] wr_data_k,      // word at k rise
    output logic [35:0] wr_data_kn,     // word at k# rise
    output logic [3:0] sel_k,           // mask at k rise
    output logic [3:0] sel_kn           // mask at k# rise
);
    logic [1:0] gap;
    logic [35:0] pd0, pd1;
    logic [3:0] pm0, pm1;
    // two idle cycles between a read and a following write
    assign ready = req_rnw || gap == 2'h0;
    always @(posedge clk) begin
        if (rst) begin
            load_request_n <= 1'b1;
            read_not_write <= 1'b0;
            gap <= 2'h0;
            wr_data_k <= 36'h0;
            wr_data_kn <= 36'h0;
            sel_k <= 4'hF;
            sel_kn <= 4'hF;
        end else if (ce) begin
            load_request_n <= !(req && ready); // op loaded at an enabled rise, cycle t
            read_not_write <= req_rnw;
            addr <= req_addr;
            {pd0, pd1, pm0, pm1} <= {req_d0, req_d1, req_m0, req_m1};
            if (req && ready && req_rnw) begin
                gap <= 2'h2;
            end else if (gap != 2'h0) begin
                gap <= gap - 2'h1;
            end
            // data follows in t + 1; outside it the lines invert each enabled cycle, so every second such cycle holds the old word again
            if (!load_request_n && !read_not_write) begin
                {wr_data_k, wr_data_kn, sel_k, sel_kn} <= {pd0, pd1, pm0, pm1};
            end else begin
                {wr_data_k, wr_data_kn, sel_k, sel_kn} <= ~{wr_data_k, wr_data_kn, sel_k, sel_kn};
            end
        end
    end
endmodule

// File: sim/tb_top.sv
// bench for the byte-masked burst sram core, wide and narrow parts side by side
// assumes the controller model in sim/ and the core under core/
`timescale 1ns/1ps
module tb_top;
    import bmw_pkg::*;
    logic clk = 0, rst = 1, ce = 1, req = 0, req_rnw = 0, rnd_ce = 0, ready;
    logic load_request_n, read_not_write, oe36, oe18;
    logic [3:0] req_addr = 0, req_m0 = 0, req_m1 = 0, addr, sk, skn;
    logic [35:0] req_d0 = 0, req_d1 = 0, wd_k, wd_kn, rd36k, rd36kn, e0, e1, sb [16][2];
    logic [17:0] rd18k, rd18kn;
    logic [31:0] seed = 32'h51, r;
    logic [35:0] q0 [$], q1 [$];
    int n_errors = 0, checks = 0, i;
    // clock never stopped in this run, so parking both phases high is moot
    always #2.5 clk = ~clk;
    bmw_ctrl_model i_ctrl (.clk(clk), .rst(rst), .ce(ce), .req(req), .req_rnw(req_rnw),
        .req_addr(req_addr), .req_d0(req_d0), .req_d1(req_d1), .req_m0(req_m0),
        .req_m1(req_m1), .ready(ready), .load_request_n(load_request_n),
        .read_not_write(read_not_write), .addr(addr), .wr_data_k(wd_k),
        .wr_data_kn(wd_kn), .sel_k(sk), .sel_kn(skn));
    bmw_top #(.WORD_W(36), .ADDR_W(4)) i_dut (.clk(clk), .rst(rst), .ce(ce),
        .load_request_n(load_request_n), .read_not_write(read_not_write), .addr(addr),
        .wr_data_k(wd_k), .wr_data_kn(wd_kn), .lane_write_select_n_k(sk),
        .lane_write_select_n_kn(skn), .rd_data_k(rd36k), .rd_data_kn(rd36kn), .dq_oe(oe36));
    bmw_top #(.WORD_W(18), .ADDR_W(4)) i_dut18 (.clk(clk), .rst(rst), .ce(ce),
        .load_request_n(load_request_n), .read_not_write(read_not_write), .addr(addr),
        .wr_data_k(wd_k[17:0]), .wr_data_kn(wd_kn[17:0]), .lane_write_select_n_k(sk[1:0]),
        .lane_write_select_n_kn(skn[1:0]), .rd_data_k(rd18k), .rd_data_kn(rd18kn),
        .dq_oe(oe18));
    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function logic [35:0] r36();
        logic [31:0] h;
        h = rnd();
        return {h[3:0], rnd()};
    endfunction
    // low select takes the new lane, high keeps the stored one
    function logic [35:0] merge(logic [35:0] o, logic [35:0] n, logic [3:0] m);
        for (int k = 0; k < 4; k++) begin
            if (!m[k]) o[9*k+:9] = n[9*k+:9];
        end
        return o;
    endfunction
    task end_sim();
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task chk(logic [35:0] seen, logic [35:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task op(bit rnw, logic [3:0] a, logic [35:0] d0, logic [35:0] d1, logic [3:0] m0,
            logic [3:0] m1);
        int n;
        {req, req_rnw, req_addr, req_d0, req_d1, req_m0, req_m1} <= {1'b1, rnw, a, d0, d1, m0, m1};
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (!(ready === 1'b1 && ce === 1'b1) && n < 200);
        if (n >= 200) begin
            n_errors++;
            end_sim();
        end
        if (rnw) begin
            q0.push_back(sb[a][0]);
            q1.push_back(sb[a][1]);
        end else begin
            sb[a][0] = merge(sb[a][0], d0, m0);
            sb[a][1] = merge(sb[a][1], d1, m1);
        end
    endtask
    task drain(string name);
        int n;
        req <= 1'b0;
        n = 0;
        while (q0.size() != 0 && n < 100) begin
            @(posedge clk);
            n++;
        end
        if (n >= 100) begin
            n_errors++;
            end_sim();
        end
        $display("test %s done", name);
    endtask
    always @(posedge clk) ce <= rnd_ce ? (rnd() % 8 != 0) : 1'b1;
    always @(posedge clk) begin
        if (!rst && ce && oe36 === 1'b1) begin
            if (q0.size() == 0) begin
                chk({35'h0, oe36}, 36'h0);
            end else begin
                e0 = q0.pop_front();
                e1 = q1.pop_front();
                chk(rd36k, e0);
                chk(rd36kn, e1);
                chk({18'h0, rd18k}, {18'h0, e0[17:0]});
                chk({18'h0, rd18kn}, {18'h0, e1[17:0]});
                chk({35'h0, oe18}, 36'h1);
            end
        end
    end
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk(rd36k, 36'h0);
        chk({35'h0, oe36}, 36'h0);
        chk({17'h0, rd18k, oe18}, 36'h0);
        for (i = 0; i < 16; i++) op(1'b0, i[3:0], r36(), r36(), 4'h0, 4'h0);
        for (i = 0; i < 16; i++) op(1'b1, i[3:0], 36'h0, 36'h0, 4'h0, 4'h0);
        drain("fill");
        // each mask value on k, its inverse on k#, read at once through the bypass
        for (i = 0; i < 16; i++) begin
            r = rnd();
            op(1'b0, r[3:0], r36(), r36(), i[3:0], ~i[3:0]);
            op(1'b1, r[3:0], 36'h0, 36'h0, 4'h0, 4'h0);
        end
        drain("lanes");
        rnd_ce <= 1'b1;
        repeat (300) begin
            r = rnd();
            op(r[0], r[4:1], r36(), r36(), r[8:5], r[12:9]);
        end
        rnd_ce <= 1'b0;
        for (i = 0; i < 16; i++) op(1'b1, i[3:0], 36'h0, 36'h0, 4'h0, 4'h0);
        drain("random");
        end_sim();
    end
endmodule
